// file: common/timer_defs.vh
// Register map, field layout and reset values of the prescaled down timer
// Included by the timer design; definitions only
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

`define ADDR_W          4
`define DATA_W          16
`define ADDR_COUNT      4'h0
`define ADDR_PERIOD     4'h1
`define ADDR_CONTROL    4'h2
`define ADDR_IRQ_FLAG   4'h3
`define ADDR_IRQ_MASK   4'h4

`define CTL_PSC_LO      0
`define CTL_PSC_HI      3
`define CTL_STOP_BIT    4
`define CTL_RELOAD_BIT  5
`define CTL_DDR_LO      6
`define CTL_DDR_HI      9

`define IRQ_TIMER_BIT   0
`define IRQ_MASK_BITS   16'h0001

`define RST_COUNT       16'hffff
`define RST_PERIOD      16'hffff
`define RST_NIBBLE      4'h0
`define RST_WORD        16'h0000
`define NIBBLE_ZERO     4'h0
`define NIBBLE_ONE      4'h1
`define WORD_ZERO       16'h0000
`define WORD_ONE        16'h0001

`endif

// file: rtl/prescaled_down_timer.v
// Prescaled down timer: 4-bit prescaler feeding a 16-bit main counter
// Assumes a synchronous register port; one clock, async active-low reset
//
// Behaviour
// R1 - Prescaler underflow past zero reloads it from divide-down and decrements main count
// R2 - Main count decrements exactly once per prescaler underflow, never otherwise
// R3 - Main count underflow or timer reset reloads from period and raises interrupt
// R4 - Divide-down ratio is a 4-bit control field, zero after reset
// R5 - Prescaler is a 4-bit control field, reloaded on underflow and timer reset
// R6 - Writing one to reload bit reloads main count and prescaler
// R7 - Stop bit halts and resumes counting, zero after reset so timer runs
// R8 - Main count is a 16-bit register readable by software
// R9 - Period is a 16-bit register giving main counter reload value
// R10 - Interrupt flag register bit is set on every main count underflow
// R11 - Stop bit high freezes both counters; low resumes decrement each clock
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer_defs.vh"

// Register map, word indices on addr
//   0      main count     RW, live value of the main down counter
//   1      period value   RW, reload value of the main counter
//   2      timer control  [3:0] prescale, [4] stop, [5] reload, [9:6] divide-down
//   3      irq flags      bit 0 timer flag, write one to clear
//   4      irq mask       bit 0 lets the timer flag reach irq
//   5..15  unmapped       writes ignored, reads return zero
//
// Bus timing
//   A write lands at the edge that samples wrEn; a read answer stands in
//   the cycle after rdEn and reads zero otherwise. The port never stalls,
//   so strobes may follow each other with no gap.
//
// Reset state
//   Main count and period both start at all ones, so the first underflow
//   comes a full period after reset. Prescale and divide-down start at
//   zero and the stop bit is clear, so the timer runs from the first
//   enabled edge after reset, one main step per clock.
//
// Counting, one step per enabled clock while running
//   prescale not zero: prescale steps down by one
//   prescale zero:     prescale reloads from divide-down, main count steps once
//   main count zero:   main count reloads from period, flag and tick raised
// One main step thus takes divide-down plus one clocks, and one interrupt
// period takes (period plus one) times (divide-down plus one) clocks.
//
// Reload bit
//   Acts as a timer reset: both counters reload and the flag is raised,
//   so software sees a tick at once rather than after a full period.
//   The bit is never stored, so it always reads back as zero.
//
// Interrupt
//   The flag is sticky; an underflow in the same cycle as a write-one
//   clear keeps the flag set, so no event is lost to a late clear.
//   irq is registered from the updated flags, one cycle after the event.
//
// Clock enable
//   Low freezes every flop, read data and outputs included, so a read
//   answer stands until the enable returns.
//
// Limitations
//   A count or control write owns the counters in its cycle, so that
//   cycle does not count; frequent control writes slow the timer.
//   Rewriting control also rewrites the prescale field from the data.

module prescaled_down_timer (
   input  wire                 clk,        // System clock
   input  wire                 rstn,       // Async reset, active low
   input  wire                 clkEn,      // Clock enable, freezes all state when low
   input  wire [`ADDR_W-1:0]   addr,       // Register address
   input  wire [`DATA_W-1:0]   wrData,     // Write data
   input  wire                 wrEn,       // Write strobe
   input  wire                 rdEn,       // Read strobe
   output reg  [`DATA_W-1:0]   rdData,     // Read data, valid the cycle after rdEn
   output reg                  irq,        // Level interrupt, unmasked flag set
   output reg                  tickPulse   // One-cycle pulse on main count underflow
);

   // Stored state
   reg  [`DATA_W-1:0] count_ff;
   reg  [`DATA_W-1:0] period_ff;
   reg  [3:0]         prescale_ff;
   reg  [3:0]         divide_ff;
   reg                stop_ff;
   reg  [`DATA_W-1:0] flag_ff;
   reg  [`DATA_W-1:0] mask_ff;

   // Next-state values and the underflow event
   reg  [`DATA_W-1:0] nxt_count;
   reg  [3:0]         nxt_prescale;
   reg  [3:0]         nxt_divide;
   reg                nxt_stop;
   reg  [`DATA_W-1:0] nxt_period;
   reg  [`DATA_W-1:0] nxt_flag;
   reg  [`DATA_W-1:0] nxt_mask;
   reg  [`DATA_W-1:0] nxt_rdData;
   reg                mainUnder;

   // Address match, shared by the write decode and the read mux
   function hitReg;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] target;
      begin
         hitReg = (a == target);
      end
   endfunction

   wire wrCount   = wrEn && hitReg(addr, `ADDR_COUNT);
   wire wrPeriod  = wrEn && hitReg(addr, `ADDR_PERIOD);
   wire wrControl = wrEn && hitReg(addr, `ADDR_CONTROL);
   wire wrFlag    = wrEn && hitReg(addr, `ADDR_IRQ_FLAG);
   wire wrMask    = wrEn && hitReg(addr, `ADDR_IRQ_MASK);

   // Views of the control word being written
   wire [3:0] wrPsc    = wrData[`CTL_PSC_HI:`CTL_PSC_LO];
   wire [3:0] wrDdr    = wrData[`CTL_DDR_HI:`CTL_DDR_LO];
   wire       wrStop   = wrData[`CTL_STOP_BIT];
   wire       wrReload = wrData[`CTL_RELOAD_BIT];
   wire       reloadReq = wrControl && wrReload;

   // A count or control write owns the counters for its cycle
   wire cpuOwns   = wrCount || wrControl;
   wire counting  = !stop_ff && !cpuOwns;
   wire preZero   = (prescale_ff == `NIBBLE_ZERO);
   wire mainZero  = (count_ff == `WORD_ZERO);

   // Control word as software sees it; reload bit always reads zero
   function [`DATA_W-1:0] packControl;
      input [3:0] ddr;
      input [3:0] prescale_count;
      input       stp;
      begin
         packControl = `WORD_ZERO;
         packControl[`CTL_DDR_HI:`CTL_DDR_LO] = ddr;
         packControl[`CTL_PSC_HI:`CTL_PSC_LO] = prescale_count;
         packControl[`CTL_STOP_BIT] = stp;
      end
   endfunction

   // Period register: plain storage
   always @* begin
      nxt_period = period_ff;
      if (wrPeriod) begin
         nxt_period = wrData;                                            // [R9]
      end
   end

   // Stored control fields; the reload bit is an action, not a field
   always @* begin
      nxt_divide = divide_ff;
      nxt_stop   = stop_ff;
      if (wrControl) begin
         nxt_divide = wrDdr;                                             // [R4]
         nxt_stop   = wrStop;                                            // [R7]
      end
   end

   // Prescaler: reload wins over a plain control write, which wins over counting
   always @* begin
      nxt_prescale = prescale_ff;
      if (reloadReq) begin
         // Takes the divide-down value being written, not the stored one
         nxt_prescale = wrDdr;                                           // [R5] [R6]
      end else if (wrControl) begin
         nxt_prescale = wrPsc;                                           // [R5]
      end else if (counting) begin                                       // [R7] [R11]
         if (preZero) begin
            nxt_prescale = divide_ff;                                    // [R1] [R5]
         end else begin
            nxt_prescale = prescale_ff - `NIBBLE_ONE;                    // [R11]
         end
      end
   end

   // Main counter and the underflow event that feeds flag and tick
   always @* begin
      nxt_count = count_ff;
      mainUnder = 1'b0;
      if (reloadReq) begin
         // Timer reset: reload and raise the interrupt as on underflow
         nxt_count = period_ff;                                          // [R6]
         mainUnder = 1'b1;                                               // [R3]
      end else if (wrCount) begin
         nxt_count = wrData;                                             // [R8]
      end else if (counting && preZero) begin                            // [R2]
         if (mainZero) begin
            nxt_count = period_ff;                                       // [R3]
            mainUnder = 1'b1;                                            // [R3] [R10]
         end else begin
            nxt_count = count_ff - `WORD_ONE;                            // [R1] [R2]
         end
      end
   end

   // Only the timer bit of the mask is storable
   always @* begin
      nxt_mask = mask_ff;
      if (wrMask) begin
         nxt_mask = wrData & `IRQ_MASK_BITS;
      end
   end

   always @* begin
      // Set wins over a write-one clear in the same cycle
      nxt_flag = flag_ff;
      if (wrFlag) begin
         nxt_flag = flag_ff & ~wrData;
      end
      if (mainUnder) begin
         nxt_flag[`IRQ_TIMER_BIT] = 1'b1;                                // [R10]
      end
   end

   always @* begin
      nxt_rdData = `WORD_ZERO;
      if (rdEn) begin
         if (hitReg(addr, `ADDR_COUNT)) begin
            nxt_rdData = count_ff;                                       // [R8]
         end else if (hitReg(addr, `ADDR_PERIOD)) begin
            nxt_rdData = period_ff;                                      // [R9]
         end else if (hitReg(addr, `ADDR_CONTROL)) begin
            nxt_rdData = packControl(divide_ff, prescale_ff, stop_ff);
         end else if (hitReg(addr, `ADDR_IRQ_FLAG)) begin
            nxt_rdData = flag_ff;
         end else if (hitReg(addr, `ADDR_IRQ_MASK)) begin
            nxt_rdData = mask_ff;
         end else begin
            nxt_rdData = `WORD_ZERO;
         end
      end
   end

   // Register file; clkEn low freezes all of it
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         period_ff   <= `RST_PERIOD;
         divide_ff   <= `RST_NIBBLE;                                     // [R4]
         stop_ff     <= 1'b0;                                            // [R7]
         mask_ff     <= `RST_WORD;
      end else if (clkEn) begin
         period_ff   <= nxt_period;
         divide_ff   <= nxt_divide;
         stop_ff     <= nxt_stop;
         mask_ff     <= nxt_mask;
      end
   end

   // Counters; reset leaves the main count equal to the reset period
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff    <= `RST_COUNT;
         prescale_ff <= `RST_NIBBLE;
      end else if (clkEn) begin
         count_ff    <= nxt_count;
         prescale_ff <= nxt_prescale;
      end
   end

   // Sticky flags
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flag_ff     <= `RST_WORD;
      end else if (clkEn) begin
         flag_ff     <= nxt_flag;
      end
   end

   // Top-level outputs, each straight from a flop
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData      <= `RST_WORD;
         irq         <= 1'b0;
         tickPulse   <= 1'b0;
      end else if (clkEn) begin
         rdData      <= nxt_rdData;
         irq         <= |(nxt_flag & nxt_mask);
         tickPulse   <= mainUnder;                                       // [R3]
      end
   end

endmodule // prescaled_down_timer

`default_nettype wire

// file: verification/timer_props_properties.sv
// Port checker for prescaled_down_timer
// Assumes register index 2 control, 3 flag, 4 mask
`timescale 1ns/100ps
`default_nettype none
module timer_props (
   input wire        clk,      // Clock
   input wire        rstn,     // Reset, low
   input wire        clkEn,    // Enable
   input wire [3:0]  addr,     // Address
   input wire [15:0] wrData,   // Write data
   input wire        wrEn,     // Write
   input wire        rdEn,     // Read
   input wire [15:0] rdData,   // Read data
   input wire        irq,      // Interrupt
   input wire        tickPulse // Underflow
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire ctlWr = clkEn && wrEn && addr == 4'h2;
   wire rdOk = clkEn && rdEn;
   chk_rd_idle: assert property ($past(clkEn) && !$past(rdEn) |-> rdData == 16'h0000) else $error("stray data");
   chk_reload_tick: assert property (ctlWr && wrData[5] |=> tickPulse) else $error("no reload tick");
   chk_stop_quiet: assert property (ctlWr && wrData[4] && !wrData[5] |=> !tickPulse [*3]) else $error("stop tick");
   chk_ctl_bits: assert property (rdOk && addr == 4'h2 |=> rdData[15:10] == 6'h00 && !rdData[5]) else $error("ctl");
   chk_flag_bits: assert property (rdOk && addr == 4'h3 |=> rdData[15:1] == 15'h0000) else $error("flag");
   chk_mask_bits: assert property (rdOk && addr == 4'h4 |=> rdData[15:1] == 15'h0000) else $error("mask");
   chk_unmapped_zero: assert property (rdOk && addr > 4'h4 |=> rdData == 16'h0000) else $error("unmapped");
   chk_count_back: assert property (clkEn && wrEn && addr == 4'h0 ##1 rdOk && addr == 4'h0
      |=> rdData == $past(wrData, 2)) else $error("count readback");
   cover property (tickPulse && irq);
   cover property (ctlWr && wrData[4]);
   cover property (rdOk && addr > 4'h4);
endmodule // timer_props
bind prescaled_down_timer timer_props u_timer_props (.clk(clk), .rstn(rstn), .clkEn(clkEn), .addr(addr),
   .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq), .tickPulse(tickPulse));
`default_nettype wire

// file: verification/prescaled_down_timer_bench.sv
// Self-checking bench for prescaled_down_timer
// Drives the register port itself; one clock
`timescale 1ns/100ps
`default_nettype none
module prescaled_down_timer_bench;
   logic clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wrData = 16'h0000;
   wire [15:0] rdData;
   wire irq, tickPulse;
   int nMismatch = 0, nChecks = 0, cyc = 0, ticks;
   prescaled_down_timer u_prescaled_down_timer (.clk(clk), .rstn(rstn), .clkEn(clkEn), .addr(addr),
      .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .irq(irq), .tickPulse(tickPulse));
   initial forever #5 clk = ~clk;
   task automatic endSim();
      if (nMismatch == 0 && nChecks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         nMismatch++;
         endSim();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      // Back-to-back writes: let one idle edge pass before raising wrEn again
      if (wrEn) @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(negedge clk);
      chk(rdData, e);
      @(posedge clk);
   endtask
   task automatic resetValues();
      rd(4'h1, 16'hffff);
      rd(4'h2, 16'h0000);
      rd(4'h3, 16'h0000);
      wr(4'h7, 16'hffff);
      rd(4'h7, 16'h0000);
   endtask
   task automatic prescaleRun();
      wr(4'h2, 16'h00d3);
      wr(4'h0, 16'h0005);
      rd(4'h0, 16'h0005);
      repeat (4) @(posedge clk);
      rd(4'h0, 16'h0005);
      rd(4'h2, 16'h00d3);
      wr(4'h2, 16'h00c3);
      // Eleven counting edges at divide 3: two decrements
      repeat (11) @(posedge clk);
      wr(4'h2, 16'h00d3);
      rd(4'h0, 16'h0003);
   endtask
   task automatic irqFlow();
      wr(4'h1, 16'h0002);
      wr(4'h4, 16'h0001);
      wr(4'h2, 16'h0030);
      @(negedge clk);
      chk({14'h0, tickPulse, irq}, 16'h0003);
      @(posedge clk);
      rd(4'h0, 16'h0002);
      rd(4'h3, 16'h0001);
      wr(4'h3, 16'h0001);
      @(negedge clk);
      chk({15'h0, irq}, 16'h0000);
      @(posedge clk);
      wr(4'h4, 16'h0000);
      wr(4'h2, 16'h0020);
      ticks = 0;
      repeat (9) begin
         @(negedge clk);
         ticks += tickPulse;
         chk({15'h0, irq}, 16'h0000);
      end
      chk(16'(ticks), 16'h0003);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      resetValues();
      prescaleRun();
      irqFlow();
      endSim();
   end
endmodule // prescaled_down_timer_bench
`default_nettype wire
